// ==== inc/vrim_pkg.sv ====
// constants and types shared by the vliw register and issue block
package vrim_pkg;
  localparam int NSLOT = 5;
  localparam int NREG = 128;
  localparam int IDXW = 7;
  localparam int DW = 32;
  localparam int NRDPORT = 15;
  localparam int MAX_WB = 5;
  localparam int NCAND = 10;
  // operation codes per slot
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_IADD = 2'h1;
  localparam logic [1:0] OP_WORD_LOAD_DISPLACEMENT_OP = 2'h2;
  localparam logic [1:0] OP_JMPF = 2'h3;
  // constant entries
  localparam logic [IDXW-1:0] IDX_ZERO = 7'h00;
  localparam logic [IDXW-1:0] IDX_ONE = 7'h01;
  localparam logic [DW-1:0] VAL_ZERO = 32'h0000_0000;
  localparam logic [DW-1:0] VAL_ONE = 32'h0000_0001;
  // register byte offsets on the bus
  localparam logic [7:0] ADDR_PROGRAM_CONTROL_STATUS_WORD = 8'h00;
  localparam logic [7:0] ADDR_RESUME = 8'h04;
  localparam logic [7:0] ADDR_BLOCK = 8'h08;
  localparam logic [7:0] ADDR_TALLY_LO = 8'h0c;
  localparam logic [7:0] ADDR_TALLY_HI = 8'h10;
  // control word layout and reset
  localparam logic [DW-1:0] PROGRAM_CONTROL_STATUS_WORD_RESET = 32'h0000_0800;
  localparam int PROGRAM_CONTROL_STATUS_WORD_CS_BIT = 11;
  localparam int PROGRAM_CONTROL_STATUS_WORD_WBE_BIT = 12;
  localparam logic [DW-1:0] PTR_RESET = 32'h0000_0000;
  localparam logic [63:0] TALLY_RESET = 64'h0;
  // latencies and delays in cycles
  localparam int LOAD_LATENCY = 3;
  localparam logic [1:0] BRANCH_DELAY = 2'h3;
endpackage : vrim_pkg

// ==== inc/vrim_rf_if.sv ====
// carrier between the issue logic and the general register file
`timescale 1ns/1ps
`default_nettype none
interface vrim_rf_if;
  import vrim_pkg::*;
  logic [NRDPORT-1:0][IDXW-1:0] rdIdx;
  logic [NRDPORT-1:0][DW-1:0] rdData;
  logic [NSLOT-1:0] wrEn;
  logic [NSLOT-1:0][IDXW-1:0] wrIdx;
  logic [NSLOT-1:0][DW-1:0] wrData;
  modport core (output rdIdx, output wrEn, output wrIdx, output wrData, input rdData);
  modport file (input rdIdx, input wrEn, input wrIdx, input wrData, output rdData);
endinterface : vrim_rf_if
`default_nettype wire

// ==== hdl/vrim_gpr_file.sv ====
// 128 x 32 general register file, fifteen reads and five writes per cycle
`timescale 1ns/1ps
`default_nettype none
module vrim_gpr_file (
  input wire logic ref_clk,
  input wire logic ce,
  vrim_rf_if.file rf
);
  import vrim_pkg::*;

  logic [DW-1:0] gpr [NREG];

  genvar p;
  generate
    for (p = 0; p < NRDPORT; p++)
    begin : g_rd
      // constant entries never come from the array
      assign rf.rdData[p] = (rf.rdIdx[p] == IDX_ZERO) ? VAL_ZERO :
                            (rf.rdIdx[p] == IDX_ONE) ? VAL_ONE :
                            gpr[rf.rdIdx[p]];
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (ce)
    begin
      for (int w = 0; w < NSLOT; w++)
      begin
        if (rf.wrEn[w] && rf.wrIdx[w] != IDX_ZERO && rf.wrIdx[w] != IDX_ONE)
        begin
          gpr[rf.wrIdx[w]] <= rf.wrData[w];
        end
      end
    end
  end
endmodule : vrim_gpr_file
`default_nettype wire

// ==== hdl/vrim_core_regs.sv ====
// five-slot vliw register file, issue rules and special registers
// What this block does
// - 128 general registers, 32 bits, 7-bit index
// - index zero always reads zero
// - index one always reads one
// - registers 2..127 carry no hardware role
// - control word resets to 0x800
// - reset value keeps timestamps in phase
// - resume target latches interrupted branch target
// - block start latches only uninterrupted branch target
// - 64-bit cycle tally counts from reset
// - one five-slot instruction every cycle
// - operation acts only when guard true
// - word load result usable three cycles later
// - branch has three delay slots
// - jump when guard true, condition false
// - load reads base plus offset into destination
// - more than five writebacks sets overflow flag
// - stall-count bit chooses tally counting mode
// - resume target updated on every interruptible jump; a software write to it in the same cycle wins over the jump
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vrim_core_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // instruction issue, one entry per slot
  input wire logic stall,
  input wire logic irqPending,
  input wire logic [vrim_pkg::NSLOT-1:0] slotValid,
  input wire logic [vrim_pkg::NSLOT-1:0][1:0] slotOp,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::IDXW-1:0] slotGuard,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::IDXW-1:0] slotSrcA,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::IDXW-1:0] slotSrcB,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::IDXW-1:0] slotDest,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::DW-1:0] slotImm,
  // data memory, read data returned in the same cycle as the request
  output logic [vrim_pkg::NSLOT-1:0] memRdEn,
  output logic [vrim_pkg::NSLOT-1:0][vrim_pkg::DW-1:0] memAddr,
  input wire logic [vrim_pkg::NSLOT-1:0][vrim_pkg::DW-1:0] memRdData,
  // control transfer
  output logic branchLoad,
  output logic [vrim_pkg::DW-1:0] branchTarget,
  output logic exceptionReq
);
  import vrim_pkg::*;

  vrim_rf_if rf ();

  vrim_gpr_file u_gpr (
    .ref_clk(ref_clk),
    .ce(ce),
    .rf(rf)
  );

  logic [DW-1:0] program_control_status_word_reg;
  logic [DW-1:0] resume_reg;
  logic [DW-1:0] block_reg;
  logic [63:0] tally_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic [NSLOT-1:0] ldV1_reg;
  logic [NSLOT-1:0][IDXW-1:0] ldDst1_reg;
  logic [NSLOT-1:0] ldV2_reg;
  logic [NSLOT-1:0][IDXW-1:0] ldDst2_reg;
  logic [NSLOT-1:0][DW-1:0] ldData2_reg;
  logic [NSLOT-1:0] memRdEn_reg;
  logic [NSLOT-1:0][DW-1:0] memAddr_reg;
  logic [1:0] dlyCnt_reg;
  logic [DW-1:0] pendTarget_reg;
  logic branchLoad_reg;
  logic [DW-1:0] branchTarget_reg;
  logic exceptionReq_reg;

  logic [NSLOT-1:0] guardOk;
  logic [NSLOT-1:0] doAdd;
  logic [NSLOT-1:0] doLoad;
  logic [NSLOT-1:0] doJump;
  logic jmpTaken;
  logic [DW-1:0] jmpTarget;
  logic wbOverflow;
  logic busAccept;
  logic swPcsw;
  logic swResume;
  logic swBlock;

  // operand read ports: guard, source a, source b for each slot
  genvar s;
  generate
    for (s = 0; s < NSLOT; s++)
    begin : g_slot
      assign rf.rdIdx[3*s] = slotGuard[s];
      assign rf.rdIdx[3*s+1] = slotSrcA[s];
      assign rf.rdIdx[3*s+2] = slotSrcB[s];
      // true is the lsb of the guard register
      assign guardOk[s] = slotValid[s] & rf.rdData[3*s][0] & ~stall;
      assign doAdd[s] = guardOk[s] & (slotOp[s] == OP_IADD);
      assign doLoad[s] = guardOk[s] & (slotOp[s] == OP_WORD_LOAD_DISPLACEMENT_OP);
      // condition register false selects the jump
      assign doJump[s] = guardOk[s] & (slotOp[s] == OP_JMPF) & ~rf.rdData[3*s+1][0];
    end
  endgenerate

  // lowest taken jump slot wins
  always_comb
  begin
    jmpTaken = 1'b0;
    jmpTarget = PTR_RESET;
    for (int j = NSLOT - 1; j >= 0; j--)
    begin
      if (doJump[j])
      begin
        jmpTaken = 1'b1;
        jmpTarget = rf.rdData[3*j+2];
      end
    end
  end

  // writeback packing: adds of this cycle, then loads at the end of their latency
  always_comb
  begin
    int nxt;
    nxt = 0;
    rf.wrEn = '0;
    rf.wrIdx = '0;
    rf.wrData = '0;
    for (int c = 0; c < NCAND; c++)
    begin
      if ((c < NSLOT) ? doAdd[c] : ldV2_reg[c-NSLOT])
      begin
        if (nxt < MAX_WB)
        begin
          rf.wrEn[nxt] = 1'b1;
          if (c < NSLOT)
          begin
            rf.wrIdx[nxt] = slotDest[c];
            rf.wrData[nxt] = rf.rdData[3*c+1] + rf.rdData[3*c+2];
          end
          else
          begin
            rf.wrIdx[nxt] = ldDst2_reg[c-NSLOT];
            rf.wrData[nxt] = ldData2_reg[c-NSLOT];
          end
        end
        nxt = nxt + 1;
      end
    end
    wbOverflow = (nxt > MAX_WB);
  end

  // load pipeline: issue at j, address out and data back at j+1, written at end of j+2
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ldV1_reg <= '0;
      ldDst1_reg <= '0;
      ldV2_reg <= '0;
      ldDst2_reg <= '0;
      ldData2_reg <= '0;
      memRdEn_reg <= '0;
      memAddr_reg <= '0;
    end
    else if (ce)
    begin
      for (int l = 0; l < NSLOT; l++)
      begin
        memRdEn_reg[l] <= doLoad[l];
        memAddr_reg[l] <= rf.rdData[3*l+1] + slotImm[l];
        ldV1_reg[l] <= doLoad[l];
        ldDst1_reg[l] <= slotDest[l];
      end
      ldV2_reg <= ldV1_reg;
      ldDst2_reg <= ldDst1_reg;
      ldData2_reg <= memRdData;
    end
  end

  // delay slots then control transfer
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dlyCnt_reg <= '0;
      pendTarget_reg <= PTR_RESET;
      branchLoad_reg <= 1'b0;
      branchTarget_reg <= PTR_RESET;
      exceptionReq_reg <= 1'b0;
    end
    else if (ce)
    begin
      branchLoad_reg <= 1'b0;
      exceptionReq_reg <= jmpTaken & irqPending;
      if (jmpTaken)
      begin
        dlyCnt_reg <= BRANCH_DELAY;
        pendTarget_reg <= jmpTarget;
      end
      else if (dlyCnt_reg != 2'h0 && !stall)
      begin
        dlyCnt_reg <= dlyCnt_reg - 2'h1;
        if (dlyCnt_reg == 2'h1)
        begin
          branchLoad_reg <= 1'b1;
          branchTarget_reg <= pendTarget_reg;
        end
      end
    end
  end

  // bus address phase and read data
  assign busAccept = hsel & htrans[1] & hready;
  assign swPcsw = wrPend_reg & (wrAddr_reg == ADDR_PROGRAM_CONTROL_STATUS_WORD);
  assign swResume = wrPend_reg & (wrAddr_reg == ADDR_RESUME);
  assign swBlock = wrPend_reg & (wrAddr_reg == ADDR_BLOCK);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= '0;
      hrdata_reg <= '0;
      hreadyout_reg <= 1'b1;
    end
    else if (ce)
    begin
      hreadyout_reg <= 1'b1;
      // writes outside the register window are ignored
      wrPend_reg <= busAccept & hwrite & (haddr[31:8] == 24'h0);
      wrAddr_reg <= haddr[7:0];
      if (busAccept && !hwrite)
      begin
        if (haddr[31:8] != 24'h0)
          hrdata_reg <= 32'h0000_0000;
        else if (haddr[7:0] == ADDR_PROGRAM_CONTROL_STATUS_WORD)
          hrdata_reg <= program_control_status_word_reg;
        else if (haddr[7:0] == ADDR_RESUME)
          hrdata_reg <= resume_reg;
        else if (haddr[7:0] == ADDR_BLOCK)
          hrdata_reg <= block_reg;
        else if (haddr[7:0] == ADDR_TALLY_LO)
          hrdata_reg <= tally_reg[31:0];
        else if (haddr[7:0] == ADDR_TALLY_HI)
          hrdata_reg <= tally_reg[63:32];
        else
          hrdata_reg <= 32'h0000_0000;
      end
    end
  end

  // control word: hardware-set overflow flag wins over a software write
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      program_control_status_word_reg <= PROGRAM_CONTROL_STATUS_WORD_RESET;
    else if (ce)
    begin
      if (swPcsw)
        program_control_status_word_reg <= hwdata;
      if (wbOverflow)
        program_control_status_word_reg[PROGRAM_CONTROL_STATUS_WORD_WBE_BIT] <= 1'b1;
    end
  end

  // branch pointers: software write takes precedence
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resume_reg <= PTR_RESET;
      block_reg <= PTR_RESET;
    end
    else if (ce)
    begin
      if (swResume)
        resume_reg <= hwdata;
      else if (jmpTaken)
        resume_reg <= jmpTarget;
      if (swBlock)
        block_reg <= hwdata;
      else if (jmpTaken && !irqPending)
        block_reg <= jmpTarget;
    end
  end

  // cycle tally
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tally_reg <= TALLY_RESET;
    else if (ce && (program_control_status_word_reg[PROGRAM_CONTROL_STATUS_WORD_CS_BIT] || !stall))
      tally_reg <= tally_reg + 64'h1;
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign memRdEn = memRdEn_reg;
  assign memAddr = memAddr_reg;
  assign branchLoad = branchLoad_reg;
  assign branchTarget = branchTarget_reg;
  assign exceptionReq = exceptionReq_reg;
endmodule : vrim_core_regs
`default_nettype wire

// ==== test/vrim_core_regs_assertions.sv ====
// port assertions for the vliw register block
`timescale 1ns/1ps
`default_nettype none
module vrim_core_regs_assertions
  import vrim_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic stall,
  input wire logic irqPending,
  input wire logic [NSLOT-1:0] slotValid,
  input wire logic [NSLOT-1:0][1:0] slotOp,
  input wire logic [NSLOT-1:0][IDXW-1:0] slotGuard,
  input wire logic [NSLOT-1:0][IDXW-1:0] slotSrcA,
  input wire logic [NSLOT-1:0][DW-1:0] slotImm,
  input wire logic [NSLOT-1:0] memRdEn,
  input wire logic [NSLOT-1:0][DW-1:0] memAddr,
  input wire logic branchLoad,
  input wire logic exceptionReq
);
  logic ldPrev;
  logic irqPrev;
  logic jmpPrev;
  logic jmpIssued;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // any slot carrying a jump this cycle
  always_comb
  begin
    jmpIssued = 1'b0;
    for (int k = 0; k < NSLOT; k++)
      jmpIssued = jmpIssued | (slotValid[k] && slotOp[k] == OP_JMPF);
  end
  // slot 0 load issue, interrupt level and jump issue in any slot, one cycle back
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ldPrev <= 1'b0;
      irqPrev <= 1'b0;
      jmpPrev <= 1'b0;
    end
    else if (ce)
    begin
      ldPrev <= !stall && slotValid[0] && slotOp[0] == OP_WORD_LOAD_DISPLACEMENT_OP;
      irqPrev <= irqPending;
      jmpPrev <= !stall && jmpIssued;
    end
  end
  sequence ldFrom(g, a);
    ce && !stall && slotValid[0] && slotOp[0] == OP_WORD_LOAD_DISPLACEMENT_OP && slotGuard[0] == g && slotSrcA[0] == a;
  endsequence
  zero_read_a: assert property (ldFrom(IDX_ONE, IDX_ZERO) |=> memRdEn[0] && memAddr[0] == $past(slotImm[0]))
    else $error("zero entry base gave wrong address");
  one_read_a: assert property (ldFrom(IDX_ONE, IDX_ONE) |=> memRdEn[0] && memAddr[0] == $past(slotImm[0]) + 1)
    else $error("one entry base gave wrong address");
  guard_false_a: assert property (ldFrom(IDX_ZERO, IDX_ZERO) |=> !memRdEn[0])
    else $error("load with false guard reached memory");
  load_req_a: assert property (memRdEn[0] |-> ldPrev)
    else $error("memory request without a load");
  stall_hold_a: assert property (ce && stall |=> memRdEn == '0)
    else $error("request issued in a stall cycle");
  brk_pulse_a: assert property (branchLoad |=> !branchLoad)
    else $error("redirect longer than one cycle");
  exc_cause_a: assert property (exceptionReq |-> irqPrev)
    else $error("exception without pending interrupt");
  exc_jump_a: assert property (exceptionReq |-> jmpPrev)
    else $error("exception without an issued jump");
endmodule : vrim_core_regs_assertions
bind vrim_core_regs vrim_core_regs_assertions u_chk (.ref_clk, .resetn, .ce, .stall, .irqPending, .slotValid,
  .slotOp, .slotGuard, .slotSrcA, .slotImm, .memRdEn, .memAddr, .branchLoad, .exceptionReq);
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the vliw register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vrim_pkg::*;
  logic ref_clk, resetn, hsel, hwrite, stall, irqPending;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, v1, v2;
  logic [NSLOT-1:0] slotValid;
  logic [NSLOT-1:0][1:0] slotOp;
  logic [NSLOT-1:0][IDXW-1:0] slotGuard, slotSrcA, slotSrcB, slotDest;
  logic [NSLOT-1:0][DW-1:0] slotImm, memRdData;
  wire logic hreadyout, hresp, branchLoad, exceptionReq;
  wire logic [31:0] hrdata, branchTarget;
  wire logic [NSLOT-1:0] memRdEn;
  wire logic [NSLOT-1:0][DW-1:0] memAddr;
  int nErrors, cmpCount;
  vrim_core_regs u_dut (.ref_clk, .resetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .stall, .irqPending, .slotValid, .slotOp, .slotGuard,
    .slotSrcA, .slotSrcB, .slotDest, .slotImm, .memRdEn, .memAddr, .memRdData, .branchLoad, .branchTarget,
    .exceptionReq);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic wrapUp();
    $display("errors %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrapUp
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  // next edge with ready high, bounded
  task automatic busWait();
    int i = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 20)
      begin
        nErrors++;
        wrapUp();
      end
      @(posedge ref_clk);
    end
  endtask : busWait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    busWait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    busWait();
    rd = hrdata;
  endtask : bus
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, v1);
    check(v1, exp);
  endtask : rdChk
  task automatic issue(input logic [1:0] op, input logic [4:0] m, input logic [6:0] g, a, b, d,
    input logic [31:0] imm);
    @(posedge ref_clk);
    slotValid <= m;
    slotOp <= {NSLOT{op}};
    slotGuard <= {NSLOT{g}};
    slotSrcA <= {NSLOT{a}};
    slotSrcB <= {NSLOT{b}};
    slotImm <= {NSLOT{imm}};
    for (int s = 0; s < NSLOT; s++)
      slotDest[s] <= d + 7'(s);
  endtask : issue
  task automatic nop();
    issue(OP_NOP, 5'h0, 7'h0, 7'h0, 7'h0, 7'h0, 32'h0);
  endtask : nop
  task automatic ldChk(input logic [6:0] g, a, input logic [31:0] imm, input logic [31:0] exp);
    issue(OP_WORD_LOAD_DISPLACEMENT_OP, 5'h1, g, a, 7'h0, 7'h0b, imm);
    nop();
    @(negedge ref_clk);
    check(memAddr[0], exp);
  endtask : ldChk
  initial
  begin
    nErrors = 0;
    cmpCount = 0;
    resetn = 1'b0;
    {hsel, hwrite, stall, irqPending, htrans, haddr, hwdata} = '0;
    {slotValid, slotOp, slotGuard, slotSrcA, slotSrcB, slotDest, slotImm} = '0;
    memRdData = {NSLOT{32'h0000_0abc}};
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rdChk(ADDR_PROGRAM_CONTROL_STATUS_WORD, PROGRAM_CONTROL_STATUS_WORD_RESET);
    check(32'(hresp), 32'h0);
    bus(1'b1, ADDR_RESUME, 32'h1234_5678, v1);
    rdChk(ADDR_RESUME, 32'h1234_5678);
    bus(1'b1, ADDR_TALLY_HI, 32'hffff_ffff, v1);
    rdChk(ADDR_TALLY_HI, 32'h0);
    rdChk(8'h40, 32'h0);
    bus(1'b0, ADDR_TALLY_LO, 32'h0, v1);
    bus(1'b0, ADDR_TALLY_LO, 32'h0, v2);
    check(v2 - v1, 32'h3);
    // stall-count select cleared: stalled cycles not counted
    bus(1'b1, ADDR_PROGRAM_CONTROL_STATUS_WORD, 32'h0, v1);
    @(posedge ref_clk) stall <= 1'b1;
    bus(1'b0, ADDR_TALLY_LO, 32'h0, v1);
    bus(1'b0, ADDR_TALLY_LO, 32'h0, v2);
    check(v2 - v1, 32'h0);
    @(posedge ref_clk) stall <= 1'b0;
    bus(1'b1, ADDR_PROGRAM_CONTROL_STATUS_WORD, PROGRAM_CONTROL_STATUS_WORD_RESET, v1);
    issue(OP_IADD, 5'h1, 7'h1, 7'h1, 7'h1, 7'h02, 32'h0);
    issue(OP_WORD_LOAD_DISPLACEMENT_OP, 5'h1, 7'h1, 7'h02, 7'h0, 7'h09, 32'h10);
    nop();
    @(negedge ref_clk);
    check(memAddr[0], 32'h12);
    check(32'(memRdEn[0]), 32'h1);
    nop();
    ldChk(7'h1, 7'h09, 32'h0, 32'h0000_0abc);
    issue(OP_IADD, 5'h1, 7'h1, 7'h1, 7'h1, 7'h00, 32'h0);
    nop();
    nop();
    ldChk(7'h1, 7'h00, 32'h20, 32'h20);
    ldChk(7'h1, 7'h01, 32'h20, 32'h21);
    issue(OP_IADD, 5'h1, 7'h1, 7'h1, 7'h0, 7'h08, 32'h0);
    issue(OP_IADD, 5'h1, 7'h0, 7'h1, 7'h1, 7'h08, 32'h0);
    ldChk(7'h1, 7'h08, 32'h0, 32'h1);
    ldChk(7'h0, 7'h0, 32'h0, 32'h0);
    check(32'(memRdEn[0]), 32'h0);
    // load and five adds retire together: one too many
    issue(OP_WORD_LOAD_DISPLACEMENT_OP, 5'h1, 7'h1, 7'h1, 7'h0, 7'h0c, 32'h0);
    nop();
    issue(OP_IADD, 5'h1f, 7'h1, 7'h1, 7'h1, 7'h14, 32'h0);
    nop();
    rdChk(ADDR_PROGRAM_CONTROL_STATUS_WORD, 32'h0000_1800);
    ldChk(7'h1, 7'h18, 32'h0, 32'h2);
    issue(OP_IADD, 5'h1, 7'h1, 7'h02, 7'h02, 7'h07, 32'h0);
    issue(OP_JMPF, 5'h1, 7'h1, 7'h1, 7'h02, 7'h0, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      nop();
      @(negedge ref_clk);
      check(32'(branchLoad), 32'h0);
    end
    issue(OP_JMPF, 5'h1, 7'h1, 7'h0, 7'h02, 7'h0, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      nop();
      @(negedge ref_clk);
      check(32'(branchLoad), 32'(i == 3));
      check(32'(exceptionReq), 32'h0);
    end
    check(branchTarget, 32'h2);
    rdChk(ADDR_BLOCK, 32'h2);
    rdChk(ADDR_RESUME, 32'h2);
    @(posedge ref_clk) irqPending <= 1'b1;
    issue(OP_JMPF, 5'h1, 7'h1, 7'h0, 7'h07, 7'h0, 32'h0);
    nop();
    @(negedge ref_clk);
    check(32'(exceptionReq), 32'h1);
    @(posedge ref_clk) irqPending <= 1'b0;
    rdChk(ADDR_RESUME, 32'h4);
    rdChk(ADDR_BLOCK, 32'h2);
    wrapUp();
  end
endmodule : tb
`default_nettype wire
